// ---- verilog/sel_regs.svh ----
// offsets, field positions, reset values and log addresses of the logs
`ifndef SEL_REGS_SVH
`define SEL_REGS_SVH
// wishbone byte offsets
`define SEL_OFS_SELECT 12'h000
`define SEL_OFS_STATUS 12'h004
`define SEL_OFS_DONE 12'h008
// log page window: adr[11] set, word index in adr[8:2]
`define SEL_WIN_BIT 11
// log addresses
`define SEL_LOG_PERF 8'h20
`define SEL_LOG_WSTR 8'h21
`define SEL_LOG_RSTR 8'h22
`define SEL_LOG_CMDERR 8'h0c
// field values and positions
`define SEL_VERSION 8'h02
`define SEL_STREAM_ERR_BIT 5
`define SEL_NON_QUEUED_BIT 7
`define SEL_DEFER_FEAT 16'hffff
`define SEL_RST_SELECT 8'h00
`define SEL_CKS_WORD 7'h7f
`endif

// ---- verilog/sel_pkg.sv ----
// types shared by the error log block
package sel_pkg;
   // one stream error reported by the media logic
   typedef struct packed {
      logic valid;
      logic is_write;
      logic deferred;
      logic [7:0] feat_prev;
      logic [7:0] feat_cur;
      logic [7:0] status;
      logic [7:0] error;
      logic [47:0] lba;
      logic [15:0] count;
   } sel_stream_evt_t;
   // one command error with its shadow register snapshot
   typedef struct packed {
      logic valid;
      logic non_queued_flag;
      logic [4:0] tag;
      logic [12:0][7:0] shadow;
   } sel_cmd_evt_t;
   // one stored stream log entry
   typedef struct packed {
      logic [15:0] feat;
      logic [7:0] status;
      logic [7:0] error;
      logic [47:0] lba;
      logic [15:0] count;
   } sel_entry_t;
   // wishbone slave state
   typedef enum logic {
      SEL_BUS_IDLE = 1'b0,
      SEL_BUS_ACK = 1'b1
   } sel_bus_st_t;
endpackage : sel_pkg

// ---- verilog/sel_logs.sv ----
// stream and command error logs behind a wishbone slave
`timescale 1ns/100ps
`include "sel_regs.svh"
module sel_logs #(
   parameter int unsigned ENTRIES = 31
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire sel_pkg::sel_stream_evt_t stream_evt_i,
   input wire sel_pkg::sel_cmd_evt_t cmd_evt_i
);
   localparam logic [4:0] LAST = 5'(ENTRIES);

   sel_pkg::sel_bus_st_t bus_q, bus_d;
   logic [31:0] rdat_q, rdat_d;
   logic [7:0] select_q, select_d;
   logic req;
   logic win;
   logic [6:0] word;
   logic done_wr;
   logic perf_wr;
   logic take_wr;
   logic stm_rd;

   // stream log state: index 0 is the read log, 1 the write log
   logic [4:0] idx_q [2];
   logic [4:0] idx_d [2];
   logic [15:0] cnt_q [2];
   logic [15:0] cnt_d [2];
   logic [31:1] vld_q [2];
   logic [31:1] vld_d [2];
   logic hit [2];
   logic clr [2];
   sel_pkg::sel_entry_t new_ent;
   sel_pkg::sel_entry_t mem [2][1:31];

   // command error record bytes 0..13 and its checksum
   logic [7:0] rec_q [14];
   logic [7:0] rec_d [14];
   logic [7:0] cks;

   // performance page, loaded by firmware
   logic [31:0] perf_mem [128];

   // bus decode
   assign req = wb_cyc_i && wb_stb_i && (bus_q == sel_pkg::SEL_BUS_IDLE);
   assign win = wb_adr_i[`SEL_WIN_BIT] && (wb_adr_i[10:9] == 2'h0);
   assign word = wb_adr_i[8:2];
   // a write lands only at the edge that sees ack high
   assign take_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign done_wr = take_wr && wb_sel_i[0]
      && (wb_adr_i == `SEL_OFS_DONE);
   assign perf_wr = take_wr && win
      && (select_q == `SEL_LOG_PERF);
   // a read of a stream log page, watched by the checks below
   assign stm_rd = req && !wb_we_i && win
      && (select_q == `SEL_LOG_RSTR || select_q == `SEL_LOG_WSTR);
   assign wb_ack_o = (bus_q == sel_pkg::SEL_BUS_ACK);
   assign wb_dat_o = rdat_q;

   // bus state, log select and read data
   always_comb begin
      bus_d = sel_pkg::SEL_BUS_IDLE;
      select_d = select_q;
      rdat_d = rdat_q;
      if (take_wr && wb_sel_i[0] && wb_adr_i == `SEL_OFS_SELECT) begin
         select_d = wb_dat_i[7:0];
      end
      if (req) begin
         bus_d = sel_pkg::SEL_BUS_ACK;
         rdat_d = 32'h0;
         if (!wb_we_i) begin
            if (win) begin
               rdat_d = page_word(select_q, word);
            end else if (wb_adr_i == `SEL_OFS_SELECT) begin
               rdat_d = {24'h0, select_q};
            end else if (wb_adr_i == `SEL_OFS_STATUS) begin
               rdat_d = {11'h0, idx_q[1], 11'h0, idx_q[0]};
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         bus_q <= sel_pkg::SEL_BUS_IDLE;
         select_q <= `SEL_RST_SELECT;
         rdat_q <= 32'h0;
      end else begin
         bus_q <= bus_d;
         select_q <= select_d;
         rdat_q <= rdat_d;
      end
   end

   // one 32-bit word of the selected log page, low byte first
   function automatic logic [31:0] page_word(
      input logic [7:0] lg,
      input logic [6:0] w
   );
      logic g;
      logic [4:0] e;
      sel_pkg::sel_entry_t ent;
      g = (lg == `SEL_LOG_WSTR);
      e = w[6:2];
      ent = mem[g][(e == 5'h0) ? 5'h1 : e];
      page_word = 32'h0;
      case (lg)
         `SEL_LOG_RSTR, `SEL_LOG_WSTR: begin
            if (w == 7'h0) begin
               // version, index, two-byte count
               page_word = {cnt_q[g], 3'h0, idx_q[g], `SEL_VERSION};
            end else if (e != 5'h0 && vld_q[g][e]) begin
               // entry #e at 10h*e
               case (w[1:0])
                  2'h0: page_word = {ent.error, ent.status, ent.feat};
                  2'h1: page_word = ent.lba[31:0];
                  2'h2: page_word = {16'h0, ent.lba[47:32]};
                  default: page_word = {16'h0, ent.count};
               endcase
            end
         end
         `SEL_LOG_CMDERR: begin
            if (w < 7'h3) begin
               page_word = {rec_q[{w[1:0], 2'h3}],
                  rec_q[{w[1:0], 2'h2}],
                  rec_q[{w[1:0], 2'h1}],
                  rec_q[{w[1:0], 2'h0}]};
            end else if (w == 7'h3) begin
               // bytes 14 and 15 are reserved, the record ends at 13
               page_word = {16'h0, rec_q[13], rec_q[12]};
            end else if (w == `SEL_CKS_WORD) begin
               page_word = {cks, 24'h0};
            end
         end
         `SEL_LOG_PERF: begin
            page_word = perf_mem[w];
         end
         default: begin
            page_word = 32'h0;
         end
      endcase
   endfunction : page_word

   // entry captured from the incoming error
   always_comb begin
      new_ent.feat = {stream_evt_i.feat_prev, stream_evt_i.feat_cur};
      if (stream_evt_i.is_write && stream_evt_i.deferred) begin
         new_ent.feat = `SEL_DEFER_FEAT;
      end
      new_ent.status = stream_evt_i.status;
      new_ent.error = stream_evt_i.error;
      new_ent.lba = stream_evt_i.lba;
      new_ent.count = stream_evt_i.count;
   end

   // index, count and valid mask of both stream logs
   always_comb begin
      for (int g = 0; g < 2; g++) begin
         hit[g] = stream_evt_i.valid
            && (stream_evt_i.is_write == g[0])
            && stream_evt_i.status[`SEL_STREAM_ERR_BIT];
         clr[g] = done_wr && (wb_dat_i[7:0] ==
            ((g == 0) ? `SEL_LOG_RSTR : `SEL_LOG_WSTR));
         idx_d[g] = clr[g] ? 5'h0 : idx_q[g];
         cnt_d[g] = clr[g] ? 16'h0 : cnt_q[g];
         vld_d[g] = clr[g] ? 31'h0 : vld_q[g];
         // an error in the clearing cycle is kept as the first entry
         if (hit[g]) begin
            // ring of 31 slots, index never 0 once filled
            idx_d[g] = (idx_d[g] >= LAST) ? 5'h1 : idx_d[g] + 5'h1;
            if (cnt_d[g] != 16'hffff) begin
               cnt_d[g] = cnt_d[g] + 16'h1;
            end
            vld_d[g][idx_d[g]] = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      for (int g = 0; g < 2; g++) begin
         if (sys_rst) begin
            idx_q[g] <= 5'h0;
            cnt_q[g] <= 16'h0;
            vld_q[g] <= 31'h0;
         end else begin
            idx_q[g] <= idx_d[g];
            cnt_q[g] <= cnt_d[g];
            vld_q[g] <= vld_d[g];
         end
      end
   end

   // entry storage, newest overwrites the oldest slot
   always_ff @(posedge mclk) begin
      for (int g = 0; g < 2; g++) begin
         if (hit[g]) begin
            mem[g][idx_d[g]] <= new_ent;
         end
      end
   end

   // command error record capture
   always_comb begin
      for (int b = 0; b < 14; b++) begin
         rec_d[b] = rec_q[b];
      end
      if (cmd_evt_i.valid) begin
         rec_d[0] = {cmd_evt_i.non_queued_flag, 2'h0,
            cmd_evt_i.non_queued_flag ? 5'h0 : cmd_evt_i.tag};
         for (int b = 1; b < 14; b++) begin
            rec_d[b] = cmd_evt_i.shadow[b - 1];
         end
         rec_d[1] = 8'h0;
         rec_d[11] = 8'h0;
      end
   end

   always_ff @(posedge mclk) begin
      for (int b = 0; b < 14; b++) begin
         if (sys_rst) begin
            rec_q[b] <= 8'h0;
         end else begin
            rec_q[b] <= rec_d[b];
         end
      end
   end

   // two's complement of the sum of the other 511 bytes
   always_comb begin
      logic [7:0] sum;
      sum = 8'h0;
      for (int b = 0; b < 14; b++) begin
         sum = sum + rec_q[b];
      end
      cks = 8'h0 - sum;
   end

   // performance page writes with byte lanes
   always_ff @(posedge mclk) begin
      for (int l = 0; l < 4; l++) begin
         if (perf_wr && wb_sel_i[l]) begin
            perf_mem[word][l*8 +: 8] <= wb_dat_i[l*8 +: 8];
         end
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // a reported command error, and a logged read stream error
   sequence s_cmd_err;
      cmd_evt_i.valid;
   endsequence
   sequence s_rd_hit;
      hit[0] && !clr[0];
   endsequence

   a_bus_ack_once: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle after request");
   a_tag_placed: assert property (
      cmd_evt_i.valid && !cmd_evt_i.non_queued_flag
      |=> rec_q[0][4:0] == $past(cmd_evt_i.tag) && !rec_q[0][7])
      else $error("tag not placed for queued error");
   a_nq_flag: assert property (
      cmd_evt_i.valid && cmd_evt_i.non_queued_flag
      |=> rec_q[0] == 8'h80)
      else $error("non-queued byte zero wrong");
   a_no_se_entry: assert property (
      !hit[0] && !clr[0] |=> $stable(cnt_q[0]) && $stable(idx_q[0]))
      else $error("read log changed without stream error");
   a_rd_idx_range: assert property (
      idx_q[0] <= 5'd31 && (cnt_q[0] != 16'h0 || idx_q[0] == 5'h0))
      else $error("read index out of range");
   a_wr_idx_range: assert property (
      idx_q[1] <= 5'd31 && ((idx_q[1] == 5'h0) == (cnt_q[1] == 16'h0)))
      else $error("write index out of range");
   a_cnt_step: assert property (
      hit[0] && !clr[0] && cnt_q[0] != 16'hffff
      |=> cnt_q[0] == $past(cnt_q[0]) + 16'h1)
      else $error("read count did not step");
   a_cnt_sat: assert property (
      cnt_q[1] == 16'hffff && !clr[1] |=> cnt_q[1] == 16'hffff)
      else $error("write count wrapped");
   a_rd_clear: assert property (
      clr[0] && !hit[0] |=> idx_q[0] == 5'h0 && cnt_q[0] == 16'h0)
      else $error("read log not cleared");
   a_wr_clear: assert property (
      clr[1] && hit[1] |=> idx_q[1] == 5'h1 && cnt_q[1] == 16'h1)
      else $error("write log clear lost the new error");
   a_ring_wrap: assert property (
      hit[1] && !clr[1] && idx_q[1] == 5'd31 |=> idx_q[1] == 5'h1)
      else $error("write index did not wrap to one");

   // read log ring wraps like the write log
   a_rd_wrap: assert property (
      s_rd_hit ##0 (idx_q[0] == 5'd31) |=> idx_q[0] == 5'h1)
      else $error("read index did not wrap to one");

   // read count holds at its ceiling
   a_rd_sat: assert property (
      cnt_q[0] == 16'hffff && !clr[0] |=> cnt_q[0] == 16'hffff)
      else $error("read count wrapped");

   // snapshot bytes follow the shadow registers
   a_shadow_kept: assert property (
      s_cmd_err |=> rec_q[2] == $past(cmd_evt_i.shadow[1])
         && rec_q[13] == $past(cmd_evt_i.shadow[12]))
      else $error("shadow snapshot not kept");
   // reserved record bits and bytes stay zero
   a_rsvd_shadow: assert property (
      s_cmd_err |=> rec_q[1] == 8'h0 && rec_q[11] == 8'h0
         && rec_q[0][6:5] == 2'h0)
      else $error("reserved record byte not zero");

   // a logged error lands in the slot the index points at
   a_entry_stored: assert property (
      hit[0] |=> mem[0][idx_q[0]].lba == $past(stream_evt_i.lba)
         && mem[0][idx_q[0]].count == $past(stream_evt_i.count))
      else $error("read log entry not stored");
   // deferred write errors carry all-ones features
   a_defer_feat: assert property (
      hit[1] && stream_evt_i.deferred
      |=> mem[1][idx_q[1]].feat == 16'hffff)
      else $error("deferred write features wrong");

   // reset empties both stream logs
   a_reset_empty: assert property (
      @(posedge mclk) disable iff (1'b0)
      sys_rst |=> idx_q[0] == 5'h0 && idx_q[1] == 5'h0
         && cnt_q[0] == 16'h0 && cnt_q[1] == 16'h0)
      else $error("stream logs not emptied by reset");
   // stream page header and reserved words
   a_version_byte: assert property (
      stm_rd && word == 7'h0 |=> wb_dat_o[7:0] == `SEL_VERSION)
      else $error("version byte wrong");
   a_rsvd_page: assert property (
      stm_rd && word != 7'h0 && word < 7'h4 |=> wb_dat_o == 32'h0)
      else $error("reserved page word not zero");
endmodule : sel_logs

// ---- verif/sel_host_model.sv ----
// wishbone host model that reads and fills the log pages
`timescale 1ns/100ps
module sel_host_model (
   input wire logic mclk,
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [3:0] sel,
   output logic [11:0] adr,
   output logic [31:0] dat,
   input wire logic [31:0] rdat,
   input wire logic ack
);
   // idle bus at time zero
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      sel = 4'h0;
      adr = 12'h000;
      dat = 32'h0;
   end
   // one classic cycle, held until ack is sampled high
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hf;
      adr <= a;
      dat <= d;
      @(posedge mclk);
      // no limit here: only the bench timeout ends a hung wait
      while (ack !== 1'b1) begin
         @(posedge mclk);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      dat <= ~d; // released data does not keep its value
      @(posedge mclk);
   endtask : xfer
endmodule : sel_host_model

// ---- verif/tb.sv ----
// self-checking bench for the stream and command error logs
`timescale 1ns/100ps
`include "sel_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
   $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module tb;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic cyc, stb, we, ack;
   logic [3:0] sel;
   logic [11:0] adr;
   logic [31:0] wdat, rdat, q;
   sel_pkg::sel_stream_evt_t sev_q = '0;
   sel_pkg::sel_cmd_evt_t cev_q = '0;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   always #5 mclk = ~mclk;
   sel_logs sel_logs_inst (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .stream_evt_i(sev_q), .cmd_evt_i(cev_q));
   sel_host_model sel_host_model_inst (.mclk(mclk), .cyc(cyc), .stb(stb),
      .we(we), .sel(sel), .adr(adr), .dat(wdat), .rdat(rdat), .ack(ack));
   // bus helpers
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      sel_host_model_inst.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [11:0] a);
      sel_host_model_inst.xfer(1'b0, a, 32'h0, q);
   endtask : rd
   task automatic pg(input logic [6:0] w);
      rd(12'h800 | {3'h0, w, 2'h0});
   endtask : pg
   // stream error held for n edges
   task automatic sev(input logic w, input logic [7:0] st,
      input logic [47:0] lba, input int n);
      sev_q <= '{1'b1, w, w, 8'h12, 8'h34, st, 8'h40, lba, 16'h0102};
      repeat (n) @(posedge mclk);
      sev_q <= '0;
      @(posedge mclk);
   endtask : sev
   task automatic t_reset;
      rd(`SEL_OFS_STATUS);
      `CHK(q, 32'h0)
      wr(`SEL_OFS_SELECT, 32'h22);
      pg(7'h00);
      `CHK(q, 32'h2)
      pg(7'h02);
      `CHK(q, 32'h0)
      rd(12'h00c);
      `CHK(q, 32'h0)
   endtask : t_reset
   task automatic t_entries;
      sev(1'b0, 8'h21, 48'h060504030201, 1);
      sev(1'b0, 8'h01, 48'h0, 1);
      sev(1'b1, 8'h20, 48'h0a0908070605, 1);
      pg(7'h00);
      `CHK(q, 32'h00010102)
      pg(7'h04);
      `CHK(q, 32'h40211234)
      pg(7'h05);
      `CHK(q, 32'h04030201)
      pg(7'h06);
      `CHK(q, 32'h00000605)
      pg(7'h07);
      `CHK(q, 32'h00000102)
      wr(`SEL_OFS_SELECT, 32'h21);
      pg(7'h00);
      `CHK(q, 32'h00010102)
      pg(7'h04);
      `CHK(q, 32'h4020ffff)
      wr(`SEL_OFS_DONE, 32'h22);
      rd(`SEL_OFS_STATUS);
      `CHK(q, 32'h00010000)
      wr(`SEL_OFS_DONE, 32'h21);
      rd(`SEL_OFS_STATUS);
      `CHK(q, 32'h0)
   endtask : t_entries
   task automatic t_same;
      // clear of the write log and a new write error at one edge
      fork
         wr(`SEL_OFS_DONE, 32'h21);
         begin
            @(posedge mclk);
            sev(1'b1, 8'h20, 48'h0, 1);
         end
      join
      rd(`SEL_OFS_STATUS);
      `CHK(q, 32'h00010000)
      for (int i = 0; i < 31; i++) sev(1'b1, 8'h20, 48'(i), 1);
      wr(`SEL_OFS_SELECT, 32'h21);
      pg(7'h00);
      `CHK(q, 32'h00200102)
      pg(7'h05);
      `CHK(q, 32'h1e)
      // mid-run reset empties the logs
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      rd(`SEL_OFS_STATUS);
      `CHK(q, 32'h0)
      wr(`SEL_OFS_SELECT, 32'h21);
      pg(7'h00);
      `CHK(q, 32'h2)
   endtask : t_same
   task automatic t_wrap;
      for (int i = 0; i < 32; i++) sev(1'b0, 8'h20, 48'(i), 1);
      wr(`SEL_OFS_SELECT, 32'h22);
      pg(7'h00);
      `CHK(q, 32'h00200102)
      pg(7'h05);
      `CHK(q, 32'h1f)
      pg(7'h09);
      `CHK(q, 32'h1)
      sev(1'b0, 8'h20, 48'h0, 65510);
      pg(7'h00);
      `CHK(q[31:16], 16'hffff)
   endtask : t_wrap
   task automatic t_cmd(input logic nq, input logic [7:0] b0);
      logic [7:0] s;
      cev_q.valid <= 1'b1;
      cev_q.non_queued_flag <= nq;
      cev_q.tag <= 5'h15;
      for (int k = 0; k < 13; k++) cev_q.shadow[k] <= 8'h10 + 8'(k);
      @(posedge mclk);
      cev_q <= '0;
      wr(`SEL_OFS_SELECT, 32'h0c);
      s = 8'h0;
      for (int w = 0; w < 128; w++) begin
         pg(7'(w));
         s = s + q[7:0] + q[15:8] + q[23:16] + q[31:24];
         if (w == 0) `CHK(q, {16'h1211, 8'h00, b0})
         if (w == 2) `CHK(q, 32'h00191817)
         if (w == 3) `CHK(q, 32'h00001c1b)
      end
      `CHK(s, 8'h0)
   endtask : t_cmd
   task automatic t_perf;
      wr(`SEL_OFS_SELECT, 32'h20);
      wr(12'h800, 32'h00020001);
      wr(12'h804, 32'h00010003);
      pg(7'h00);
      `CHK(q, 32'h00020001)
      pg(7'h01);
      `CHK(q, 32'h00010003)
   endtask : t_perf
   task automatic final_report;
      if (num_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : final_report
   // cut a hung run short
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 90000) begin
         num_errors++;
         final_report();
      end
   end
   // main sequence
   initial begin
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_entries();
      t_same();
      t_cmd(1'b0, 8'h15);
      t_cmd(1'b1, 8'h80);
      t_perf();
      t_wrap();
      final_report();
   end
endmodule : tb
